// *** include/sdram_bank_pkg.sv ***
package sdram_bank_pkg;

	// ----------------------------------------------------------------
	// clock and timing
	// ----------------------------------------------------------------
	localparam int CLOCK_PERIOD_NS = 100;
	localparam int PRECHARGE_TIME_NS = 20;
	localparam int REFRESH_CYCLE_TIME_NS = 70;
	localparam int MODE_LOAD_TIME_NS = 20;
	localparam int WRITE_RECOVERY_TIME_NS = 15;
	localparam int ACTIVATE_TO_ACCESS_TIME_NS = 20;

	// least times round up to whole cycles
	localparam logic [7:0] PRECHARGE_CYC =
		8'((PRECHARGE_TIME_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS);
	localparam logic [7:0] REFRESH_CYC =
		8'((REFRESH_CYCLE_TIME_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS);
	localparam logic [7:0] MODE_LOAD_CYC =
		8'((MODE_LOAD_TIME_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS);
	localparam logic [7:0] WRITE_RECOVERY_CYC =
		8'((WRITE_RECOVERY_TIME_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS);
	localparam logic [7:0] ACTIVATE_CYC =
		8'((ACTIVATE_TO_ACCESS_TIME_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS);

	// ----------------------------------------------------------------
	// data path figures
	// ----------------------------------------------------------------
	localparam int READ_LATENCY = 2;
	localparam int NUM_BANKS = 4;
	localparam logic [3:0] BURST_RELOAD = 4'd2; // burst of four: command beat plus three
	localparam logic [7:0] TIMER_RESET = 8'h00;

	// ----------------------------------------------------------------
	// types
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		BANK_IDLE = 3'b000,
		BANK_ACTIVATING = 3'b001,
		BANK_ACTIVE = 3'b010,
		BANK_READ = 3'b011,
		BANK_WRITE = 3'b100,
		BANK_READ_AP = 3'b101,
		BANK_WRITE_AP = 3'b110,
		BANK_PRECHARGING = 3'b111
	} bank_state_t;

	typedef enum logic [1:0] {
		DEV_NORMAL = 2'b00,
		DEV_REFRESH = 2'b01,
		DEV_MODE_LOAD = 2'b10,
		DEV_PRECHARGE_ALL = 2'b11
	} dev_state_t;

	typedef enum logic [3:0] {
		CMD_DESELECT = 4'h0,
		CMD_NOP = 4'h1,
		CMD_ACTIVATE = 4'h2,
		CMD_READ = 4'h3,
		CMD_WRITE = 4'h4,
		CMD_PRECHARGE = 4'h5,
		CMD_REFRESH = 4'h6,
		CMD_MODE_LOAD = 4'h7,
		CMD_BURST_STOP = 4'h8
	} cmd_t;

	typedef struct packed {
		bank_state_t state;
		logic [7:0] cnt;
		logic prech;
	} bank_t;

endpackage

// *** hw/sdram_bank_ctrl.sv ***
// Functional notes
// - read with auto precharge holds its state until precharge time passes, then idle
// - write with auto precharge holds its state until write recovery and precharge time pass, then idle
// - auto refresh runs for the refresh cycle time, then every bank is idle
// - mode load runs for the mode load time, then all banks are idle
// - precharge-all runs for the precharge time, then every bank is idle
// - precharge of an idle bank leaves it unchanged, acting as no-op
// - burst terminate acts on the latest plain read or write burst, whatever its bank
// - decode chip select, row strobe, column strobe and write enable into commands
// - an idle bank accepts its usual commands whatever other banks are doing
// - activate, read, write, precharge to another bank accepted while one bank is busy
// - an interrupted auto-precharge burst starts its own precharge automatically
// - read to another bank replaces old read data one read latency later
// - read interrupts a plain write at once; last write word is the prior clock's
// - write interrupts a plain write at once; last word is the prior clock's
// - read interrupting a read with auto precharge starts its precharge at once
// - write interrupting a read with auto precharge starts its precharge at once
// - read interrupting a write with auto precharge: precharge after write recovery
// - write interrupting a write with auto precharge: precharge after write recovery
// - activate enters activating state for activate-to-access time, then row active
`timescale 1ns/1ns

module sdram_bank_ctrl
	import sdram_bank_pkg::*;
(
	input wire logic clock, // system clock
	input wire logic rst_n, // asynchronous reset, active low
	input wire logic clkEn, // low freezes all state
	input wire logic csN, // chip select, active low
	input wire logic rasN, // row strobe, active low
	input wire logic casN, // column strobe, active low
	input wire logic weN, // write enable, active low
	input wire logic [1:0] bankAddr, // bank select
	input wire logic autoPre, // auto precharge / precharge-all select
	output logic [11:0] bankState, // state of banks 3..0, three bits each
	output logic [1:0] devState, // device-wide timed state
	output logic illegalCmd, // command refused in the previous cycle
	output logic rdDataValid, // read data on the bus
	output logic [1:0] rdDataBank, // bank owning the read data
	output logic wrDataValid, // write word taken in the previous cycle
	output logic [1:0] wrDataBank, // bank that took that write word
	output logic [3:0] apBegin // auto-precharge phase began, per bank
);

	// ----------------------------------------------------------------
	// state record
	// ----------------------------------------------------------------
	typedef struct packed {
		bank_t [NUM_BANKS-1:0] bank;
		dev_state_t devSt;
		logic [7:0] devCnt;
		logic burstOn;
		logic burstWr;
		logic [1:0] owner;
		logic [3:0] burstLeft;
		logic [READ_LATENCY-1:0][2:0] rdPipe;
		logic illegal;
		logic wrValid;
		logic [1:0] wrBank;
		logic [3:0] apBegin;
	} ctrl_t;

	ctrl_t stReg;
	ctrl_t stNext;
	cmd_t cmd;
	logic legal;
	logic allIdle;
	logic allPrechOk;
	logic newBurst;
	logic endNow;
	logic rdBeat;
	logic wrBeat;
	bank_state_t tgtSt;

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------

	// pin levels to command
	function automatic cmd_t decodeCmd(input logic cs, input logic ras, input logic cas,
		input logic we);
		cmd_t c;
		c = CMD_NOP;
		if (cs)
			c = CMD_DESELECT;
		else
		begin
			case ({ras, cas, we})
				3'b111: c = CMD_NOP;
				3'b011: c = CMD_ACTIVATE;
				3'b101: c = CMD_READ;
				3'b100: c = CMD_WRITE;
				3'b010: c = CMD_PRECHARGE;
				3'b001: c = CMD_REFRESH;
				3'b000: c = CMD_MODE_LOAD;
				default: c = CMD_BURST_STOP;
			endcase
		end
		return c;
	endfunction

	// a bank that may take a column command or a precharge
	function automatic logic openBank(input bank_state_t s);
		return (s == BANK_ACTIVE) || (s == BANK_READ) || (s == BANK_WRITE);
	endfunction

	// close a burst: plain bursts fall back to active, auto precharge starts its phase
	function automatic bank_t closeBurst(input bank_t bk);
		bank_t r;
		r = bk;
		if ((bk.state == BANK_READ) || (bk.state == BANK_WRITE))
			r.state = BANK_ACTIVE;
		else if (bk.state == BANK_READ_AP)
		begin
			r.prech = 1'b1;
			r.cnt = PRECHARGE_CYC;
		end
		else if (bk.state == BANK_WRITE_AP)
		begin
			r.prech = 1'b1;
			r.cnt = 8'(WRITE_RECOVERY_CYC + PRECHARGE_CYC);
		end
		return r;
	endfunction

	// ----------------------------------------------------------------
	// command decode and legality
	// ----------------------------------------------------------------

	// decode and check the command against the current bank states
	always_comb
	begin
		cmd = decodeCmd(csN, rasN, casN, weN);
		tgtSt = stReg.bank[bankAddr].state;
		allIdle = 1'b1;
		allPrechOk = 1'b1;
		for (int i = 0; i < NUM_BANKS; i++)
		begin
			if (stReg.bank[i].state != BANK_IDLE)
				allIdle = 1'b0;
			if (!openBank(stReg.bank[i].state) && (stReg.bank[i].state != BANK_IDLE))
				allPrechOk = 1'b0;
		end
		case (cmd)
			CMD_DESELECT, CMD_NOP: legal = 1'b1;
			CMD_ACTIVATE: legal = (tgtSt == BANK_IDLE);
			CMD_READ, CMD_WRITE: legal = openBank(tgtSt);
			CMD_PRECHARGE: legal = autoPre ? allPrechOk
				: (openBank(tgtSt) || (tgtSt == BANK_IDLE));
			CMD_REFRESH, CMD_MODE_LOAD: legal = allIdle;
			CMD_BURST_STOP: legal = stReg.burstOn
				&& openBank(stReg.bank[stReg.owner].state);
			default: legal = 1'b0;
		endcase
		// nothing but deselect or no-op while the device is busy
		if ((stReg.devSt != DEV_NORMAL) && (cmd != CMD_DESELECT) && (cmd != CMD_NOP))
			legal = 1'b0;
		newBurst = legal && ((cmd == CMD_READ) || (cmd == CMD_WRITE));
		endNow = stReg.burstOn && ((stReg.burstLeft == 4'd0)
			|| (legal && (cmd == CMD_BURST_STOP))
			|| (newBurst && (stReg.owner != bankAddr)));
		rdBeat = (newBurst && (cmd == CMD_READ)) || (stReg.burstOn && !stReg.burstWr
			&& !newBurst && !(legal && (cmd == CMD_BURST_STOP))
			&& !(legal && (cmd == CMD_PRECHARGE)));
		wrBeat = (newBurst && (cmd == CMD_WRITE)) || (stReg.burstOn && stReg.burstWr
			&& !newBurst && !(legal && (cmd == CMD_BURST_STOP))
			&& !(legal && (cmd == CMD_PRECHARGE)));
	end

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------

	// timers, burst progress, then the new command
	always_comb
	begin
		stNext = stReg;
		if (clkEn)
		begin
			// pulses last one enabled cycle and hold while the clock enable is low
			stNext.illegal = 1'b0;
			stNext.apBegin = 4'h0;
			// per-bank down-counters
			for (int i = 0; i < NUM_BANKS; i++)
			begin
				if ((stReg.bank[i].state == BANK_ACTIVATING)
					|| (stReg.bank[i].state == BANK_PRECHARGING) || stReg.bank[i].prech)
				begin
					if (stReg.bank[i].cnt > 8'd1)
						stNext.bank[i].cnt = stReg.bank[i].cnt - 8'd1;
					else
					begin
						stNext.bank[i].cnt = TIMER_RESET;
						stNext.bank[i].prech = 1'b0;
						stNext.bank[i].state = (stReg.bank[i].state == BANK_ACTIVATING)
							? BANK_ACTIVE : BANK_IDLE;
					end
				end
			end
			// device-wide timer
			if (stReg.devSt != DEV_NORMAL)
			begin
				if (stReg.devCnt > 8'd1)
					stNext.devCnt = stReg.devCnt - 8'd1;
				else
				begin
					stNext.devCnt = TIMER_RESET;
					stNext.devSt = DEV_NORMAL;
				end
			end
			// burst progress and interruption
			if (stReg.burstOn)
				stNext.burstLeft = stReg.burstLeft - 4'd1;
			if (endNow)
			begin
				stNext.bank[stReg.owner] = closeBurst(stReg.bank[stReg.owner]);
				stNext.apBegin[stReg.owner] = stReg.bank[stReg.owner].state[2]
					&& (stReg.bank[stReg.owner].state != BANK_WRITE);
				stNext.burstOn = 1'b0;
			end
			// command effects
			if (!legal)
				stNext.illegal = 1'b1;
			else
			begin
				case (cmd)
					CMD_ACTIVATE:
					begin
						stNext.bank[bankAddr].state = BANK_ACTIVATING;
						stNext.bank[bankAddr].cnt = ACTIVATE_CYC;
					end
					CMD_READ, CMD_WRITE:
					begin
						if (cmd == CMD_READ)
							stNext.bank[bankAddr].state = autoPre ? BANK_READ_AP : BANK_READ;
						else
							stNext.bank[bankAddr].state = autoPre ? BANK_WRITE_AP : BANK_WRITE;
						stNext.bank[bankAddr].prech = 1'b0;
						stNext.burstOn = 1'b1;
						stNext.burstWr = (cmd == CMD_WRITE);
						stNext.owner = bankAddr;
						stNext.burstLeft = BURST_RELOAD;
					end
					CMD_PRECHARGE:
					begin
						for (int i = 0; i < NUM_BANKS; i++)
						begin
							if ((autoPre || (bankAddr == 2'(i)))
								&& (stReg.bank[i].state != BANK_IDLE))
							begin
								stNext.bank[i].state = BANK_PRECHARGING;
								stNext.bank[i].cnt = PRECHARGE_CYC;
								stNext.bank[i].prech = 1'b0;
								if (stReg.burstOn && (stReg.owner == 2'(i)))
									stNext.burstOn = 1'b0;
							end
						end
						if (autoPre)
						begin
							stNext.devSt = DEV_PRECHARGE_ALL;
							stNext.devCnt = PRECHARGE_CYC;
						end
					end
					CMD_REFRESH:
					begin
						stNext.devSt = DEV_REFRESH;
						stNext.devCnt = REFRESH_CYC;
					end
					CMD_MODE_LOAD:
					begin
						stNext.devSt = DEV_MODE_LOAD;
						stNext.devCnt = MODE_LOAD_CYC;
					end
					default:
					begin
					end
				endcase
			end
			// read latency pipeline and write word capture
			for (int i = READ_LATENCY - 1; i > 0; i--)
				stNext.rdPipe[i] = stReg.rdPipe[i-1];
			stNext.rdPipe[0] = {rdBeat, newBurst ? bankAddr : stReg.owner};
			stNext.wrValid = wrBeat;
			stNext.wrBank = newBurst ? bankAddr : stReg.owner;
		end
	end

	// ----------------------------------------------------------------
	// registers and outputs
	// ----------------------------------------------------------------

	// single state register
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
			stReg <= '0;
		else
			stReg <= stNext;
	end

	// outputs taken straight from the state register
	assign bankState = {stReg.bank[3].state, stReg.bank[2].state,
		stReg.bank[1].state, stReg.bank[0].state};
	assign devState = stReg.devSt;
	assign illegalCmd = stReg.illegal;
	assign rdDataValid = stReg.rdPipe[READ_LATENCY-1][2];
	assign rdDataBank = stReg.rdPipe[READ_LATENCY-1][1:0];
	assign wrDataValid = stReg.wrValid;
	assign wrDataBank = stReg.wrBank;
	assign apBegin = stReg.apBegin;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------

	sequence s_readIssue;
		clkEn && legal && (cmd == CMD_READ);
	endsequence

	sequence s_bank0Interrupted(bank_state_t s);
		clkEn && (stReg.bank[0].state == s) && stReg.burstOn && (stReg.owner == 2'd0)
			&& newBurst && (bankAddr != 2'd0);
	endsequence

	property p_rdApEnd;
		@(posedge clock) disable iff (!rst_n)
		(clkEn && stReg.bank[0].state == BANK_READ_AP && stReg.bank[0].prech
			&& stReg.bank[0].cnt == 8'd1) |=> (stReg.bank[0].state == BANK_IDLE);
	endproperty
	a_rdApEnd: assert property (p_rdApEnd) else $error("read-ap bank not idle");

	property p_wrApEnd;
		@(posedge clock) disable iff (!rst_n)
		(clkEn && stReg.bank[0].state == BANK_WRITE_AP && stReg.bank[0].prech
			&& stReg.bank[0].cnt == 8'd1) |=> (stReg.bank[0].state == BANK_IDLE);
	endproperty
	a_wrApEnd: assert property (p_wrApEnd) else $error("write-ap bank not idle");

	property p_refreshEnd;
		@(posedge clock) disable iff (!rst_n)
		(clkEn && legal && cmd == CMD_REFRESH) ##1 clkEn[*1]
			|=> (stReg.devSt == DEV_NORMAL && bankState == 12'h000);
	endproperty
	a_refreshEnd: assert property (p_refreshEnd) else $error("refresh overran");

	property p_modeEnd;
		@(posedge clock) disable iff (!rst_n)
		(clkEn && legal && cmd == CMD_MODE_LOAD) |=> (devState == DEV_MODE_LOAD)
			##1 (!$past(clkEn) || (devState == DEV_NORMAL));
	endproperty
	a_modeEnd: assert property (p_modeEnd) else $error("mode load timing wrong");

	property p_prechAllEnd;
		@(posedge clock) disable iff (!rst_n)
		(clkEn && legal && cmd == CMD_PRECHARGE && autoPre) ##1 clkEn
			|=> (devState == DEV_NORMAL && bankState == 12'h000);
	endproperty
	a_prechAllEnd: assert property (p_prechAllEnd) else $error("banks not idle");

	property p_idlePrecharge;
		@(posedge clock) disable iff (!rst_n)
		(clkEn && cmd == CMD_PRECHARGE && !autoPre && bankAddr == 2'd0
			&& stReg.devSt == DEV_NORMAL && stReg.bank[0].state == BANK_IDLE)
			|=> (stReg.bank[0].state == BANK_IDLE && !illegalCmd);
	endproperty
	a_idlePrecharge: assert property (p_idlePrecharge) else $error("idle precharge");

	property p_rdLatency;
		@(posedge clock) disable iff (!rst_n)
		(s_readIssue ##1 clkEn) |=> (rdDataValid && rdDataBank == $past(bankAddr, 2));
	endproperty
	a_rdLatency: assert property (p_rdLatency) else $error("read data late");

	property p_rdApInterrupt;
		@(posedge clock) disable iff (!rst_n)
		s_bank0Interrupted(BANK_READ_AP)
			|=> (stReg.bank[0].prech && stReg.bank[0].cnt == PRECHARGE_CYC && apBegin[0]);
	endproperty
	a_rdApInterrupt: assert property (p_rdApInterrupt) else $error("no ap start");

	property p_wrApInterrupt;
		@(posedge clock) disable iff (!rst_n)
		s_bank0Interrupted(BANK_WRITE_AP) |=> (stReg.bank[0].prech
			&& stReg.bank[0].cnt == 8'(WRITE_RECOVERY_CYC + PRECHARGE_CYC));
	endproperty
	a_wrApInterrupt: assert property (p_wrApInterrupt) else $error("no recovery");

	property p_activate;
		@(posedge clock) disable iff (!rst_n)
		(clkEn && legal && cmd == CMD_ACTIVATE && bankAddr == 2'd0) ##1 clkEn
			|=> (stReg.bank[0].state == BANK_ACTIVE);
	endproperty
	a_activate: assert property (p_activate) else $error("bank not active");

	property p_illegalHolds;
		@(posedge clock) disable iff (!rst_n)
		(clkEn && !legal && stReg.devSt == DEV_NORMAL && cmd == CMD_ACTIVATE)
			|=> (illegalCmd && $stable(devState));
	endproperty
	a_illegalHolds: assert property (p_illegalHolds) else $error("illegal missed");

endmodule // sdram_bank_ctrl

// *** test/sdram_ctrl_model.sv ***
`timescale 1ns/1ns

module sdram_ctrl_model
	import sdram_bank_pkg::*;
(
	input wire logic clock, // system clock
	output logic csN, // chip select, active low
	output logic rasN, // row strobe, active low
	output logic casN, // column strobe, active low
	output logic weN, // write enable, active low
	output logic [1:0] bankAddr, // target bank
	output logic autoPre // auto precharge or all banks
);
	// ----------------------------------------------------------------
	// command drive
	// ----------------------------------------------------------------
	// pins start as a no-op so nothing is taken while reset is held
	initial
	begin
		{csN, rasN, casN, weN} = 4'h7;
		bankAddr = 2'h0;
		autoPre = 1'b0;
	end

	// called at a falling edge; holds one command through the next rising edge
	task automatic issue(input cmd_t c, input logic [1:0] b, input logic ap);
		logic [3:0] pins;
		case (c)
			CMD_DESELECT: pins = 4'h8;
			CMD_ACTIVATE: pins = 4'h3;
			CMD_READ: pins = 4'h5;
			CMD_WRITE: pins = 4'h4;
			CMD_PRECHARGE: pins = 4'h2;
			CMD_REFRESH: pins = 4'h1;
			CMD_MODE_LOAD: pins = 4'h0;
			CMD_BURST_STOP: pins = 4'h6;
			default: pins = 4'h7;
		endcase
		{csN, rasN, casN, weN} = pins;
		bankAddr = b;
		autoPre = ap;
		@(negedge clock);
	endtask

	// no-op for k cycles; released address lines flip so stale values never match
	task automatic idle(input int k);
		{csN, rasN, casN, weN} = 4'h7;
		bankAddr = ~bankAddr;
		autoPre = ~autoPre;
		repeat (k) @(negedge clock);
	endtask
endmodule // sdram_ctrl_model

// *** test/sdram_bank_state_command_rules_test.sv ***
`timescale 1ns/1ns

module sdram_bank_state_command_rules_test;
	import sdram_bank_pkg::*;

	// ----------------------------------------------------------------
	// signals and instances
	// ----------------------------------------------------------------
	logic clock, rst_n, clkEn;
	logic csN, rasN, casN, weN, autoPre, illegalCmd, rdDataValid, wrDataValid;
	logic [1:0] bankAddr, devState, rdDataBank, wrDataBank;
	logic [11:0] bankState;
	logic [3:0] apBegin;
	int n_fail = 0;
	int num_checks = 0;
	int cycles = 0;
	// observed values packed to one width: valid flag over owning bank
	wire logic [2:0] ill = {2'b0, illegalCmd};
	wire logic [2:0] dev = {1'b0, devState};
	wire logic [2:0] rd = {rdDataValid, rdDataBank};
	wire logic [2:0] rv = {2'b0, rdDataValid};
	wire logic [2:0] wr = {wrDataValid, wrDataBank};
	wire logic [2:0] wv = {2'b0, wrDataValid};
	wire logic [2:0] ap0 = {2'b0, apBegin[0]};

	// 10 MHz clock
	initial
	begin
		clock = 1'b0;
		forever #50 clock = ~clock;
	end

	sdram_ctrl_model ctl (.clock(clock), .csN(csN), .rasN(rasN), .casN(casN), .weN(weN),
		.bankAddr(bankAddr), .autoPre(autoPre));

	sdram_bank_ctrl dut_u (.clock(clock), .rst_n(rst_n), .clkEn(clkEn), .csN(csN),
		.rasN(rasN), .casN(casN), .weN(weN), .bankAddr(bankAddr), .autoPre(autoPre),
		.bankState(bankState), .devState(devState), .illegalCmd(illegalCmd),
		.rdDataValid(rdDataValid), .rdDataBank(rdDataBank), .wrDataValid(wrDataValid),
		.wrDataBank(wrDataBank), .apBegin(apBegin));

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	function automatic logic [2:0] bs(int b);
		return bankState[3 * b +: 3];
	endfunction

	task automatic chk(string n, logic [2:0] e, logic [2:0] g);
		num_checks++;
		if (g !== e)
		begin
			n_fail++;
			$display("wrong value %s: expected %h, seen %h", n, e, g);
		end
	endtask

	task automatic st(int b, bank_state_t e);
		chk($sformatf("bank%0d", b), e, bs(b));
	endtask

	task automatic cmd(cmd_t k, logic [1:0] b = 2'h0, logic ap = 1'b0);
		ctl.issue(k, b, ap);
	endtask

	task automatic nop(int k);
		ctl.idle(k);
	endtask

	// waits a bounded time for a bank to fall idle
	task automatic waitIdle(int b, int lim);
		for (int i = 0; i < lim && bs(b) !== BANK_IDLE; i++)
			nop(1);
		st(b, BANK_IDLE);
	endtask

	task automatic end_of_test();
		$display("checks %0d, mismatches %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	// deselect, refresh with a refused command inside it, mode load
	task automatic tDevice();
		cmd(CMD_DESELECT);
		chk("dev", 3'h0, dev);
		cmd(CMD_REFRESH);
		chk("dev", 3'h1, dev);
		cmd(CMD_ACTIVATE);
		chk("ill", 3'h1, ill);
		chk("dev", 3'h0, dev);
		st(0, BANK_IDLE);
		cmd(CMD_MODE_LOAD);
		chk("dev", 3'h2, dev);
		nop(1);
		chk("dev", 3'h0, dev);
		$display("test device done");
	endtask

	// activation timing, refusals, idle precharge, back-to-back activates
	task automatic tActivate();
		cmd(CMD_ACTIVATE, 2'h0);
		st(0, BANK_ACTIVATING);
		cmd(CMD_ACTIVATE, 2'h0);
		chk("ill", 3'h1, ill);
		st(0, BANK_ACTIVE);
		cmd(CMD_PRECHARGE, 2'h2);
		chk("ill", 3'h0, ill);
		st(2, BANK_IDLE);
		cmd(CMD_REFRESH);
		chk("ill", 3'h1, ill);
		chk("dev", 3'h0, dev);
		cmd(CMD_ACTIVATE, 2'h1);
		cmd(CMD_ACTIVATE, 2'h2);
		cmd(CMD_ACTIVATE, 2'h3);
		chk("ill", 3'h0, ill);
		nop(1);
		for (int b = 0; b < 4; b++)
			st(b, BANK_ACTIVE);
		$display("test activate done");
	endtask

	// full read burst, then a read interrupted by a read to another bank
	task automatic tRead();
		cmd(CMD_READ, 2'h1);
		st(1, BANK_READ);
		chk("rdv", 3'h0, rv);
		repeat (4)
		begin
			nop(1);
			chk("rd", 3'h5, rd);
		end
		nop(1);
		chk("rdv", 3'h0, rv);
		st(1, BANK_ACTIVE);
		cmd(CMD_READ, 2'h0);
		cmd(CMD_READ, 2'h1);
		st(0, BANK_ACTIVE);
		chk("rd", 3'h4, rd);
		nop(1);
		chk("rd", 3'h5, rd);
		nop(4);
		$display("test read done");
	endtask

	// plain write interrupted by a read, then by a write
	task automatic tWrite();
		for (int i = 0; i < 2; i++)
		begin
			cmd(CMD_WRITE, 2'h1);
			chk("wr", 3'h5, wr);
			cmd(i ? CMD_WRITE : CMD_READ, 2'h2);
			st(1, BANK_ACTIVE);
			chk("wr", i ? 3'h6 : 3'h0, i ? wr : wv);
			nop(1);
			if (i == 0)
				chk("rd", 3'h6, rd);
			nop(5);
		end
		$display("test write done");
	endtask

	// burst terminate hits the latest burst; without a burst it is refused
	task automatic tBurstStop();
		cmd(CMD_READ, 2'h0);
		cmd(CMD_READ, 2'h1);
		cmd(CMD_BURST_STOP, 2'h3);
		chk("ill", 3'h0, ill);
		st(1, BANK_ACTIVE);
		st(3, BANK_ACTIVE);
		cmd(CMD_BURST_STOP);
		chk("ill", 3'h1, ill);
		nop(1);
		chk("ill", 3'h0, ill);
		nop(3);
		$display("test burst stop done");
	endtask

	// auto-precharge bursts in bank 0 interrupted from bank 1
	task automatic tApInt();
		for (int i = 0; i < 4; i++)
		begin
			cmd(i[1] ? CMD_WRITE : CMD_READ, 2'h0, 1'b1);
			st(0, i[1] ? BANK_WRITE_AP : BANK_READ_AP);
			cmd(i[0] ? CMD_WRITE : CMD_READ, 2'h1);
			chk("ap0", 3'h1, ap0);
			if (i == 3)
				chk("wr", 3'h5, wr);
			nop(1);
			chk("idle0", i[1] ? 3'h0 : 3'h1, {2'b0, bs(0) == BANK_IDLE});
			nop(1);
			st(0, BANK_IDLE);
			nop(3);
			cmd(CMD_ACTIVATE, 2'h0);
			nop(1);
		end
		$display("test ap interrupt done");
	endtask

	// auto-precharge bursts that run to their end
	task automatic tApEnd();
		for (int i = 0; i < 2; i++)
		begin
			cmd(i ? CMD_WRITE : CMD_READ, 2'h0, 1'b1);
			repeat (3)
			begin
				st(0, i ? BANK_WRITE_AP : BANK_READ_AP);
				nop(1);
			end
			waitIdle(0, 6);
			cmd(CMD_ACTIVATE, 2'h0);
			nop(1);
		end
		$display("test ap end done");
	endtask

	// precharge-all refused while a bank precharges, then accepted
	task automatic tPreAll();
		cmd(CMD_PRECHARGE, 2'h0);
		st(0, BANK_PRECHARGING);
		cmd(CMD_PRECHARGE, 2'h0, 1'b1);
		chk("ill", 3'h1, ill);
		cmd(CMD_PRECHARGE, 2'h0, 1'b1);
		chk("dev", 3'h3, dev);
		nop(1);
		chk("dev", 3'h0, dev);
		for (int b = 0; b < 4; b++)
			st(b, BANK_IDLE);
		$display("test precharge all done");
	endtask

	// clock enable low freezes an activating bank and ignores a command
	task automatic tFreeze();
		cmd(CMD_ACTIVATE, 2'h2);
		clkEn = 1'b0;
		cmd(CMD_ACTIVATE, 2'h3);
		st(2, BANK_ACTIVATING);
		st(3, BANK_IDLE);
		clkEn = 1'b1;
		nop(1);
		st(2, BANK_ACTIVE);
		$display("test freeze done");
	endtask

	// reset in mid-run clears a bank that is activating
	task automatic tReset();
		cmd(CMD_ACTIVATE, 2'h1);
		rst_n = 1'b0;
		nop(1);
		st(1, BANK_IDLE);
		rst_n = 1'b1;
		nop(1);
		st(1, BANK_IDLE);
		$display("test reset done");
	endtask

	// ----------------------------------------------------------------
	// main sequence and watchdog
	// ----------------------------------------------------------------
	initial
	begin
		rst_n = 1'b0;
		clkEn = 1'b1;
		repeat (10) @(negedge clock);
		rst_n = 1'b1;
		tDevice();
		tActivate();
		tRead();
		tWrite();
		tBurstStop();
		tApInt();
		tApEnd();
		tPreAll();
		tFreeze();
		tReset();
		end_of_test();
	end

	// cuts a hang short well past the expected run length
	always @(posedge clock)
	begin
		cycles++;
		if (cycles == 1000)
		begin
			n_fail++;
			end_of_test();
		end
	end
endmodule // sdram_bank_state_command_rules_test
